/* rtl/host_port_defs.vh */
// Constants for the SRAM-like host port pin block
`ifndef HOST_PORT_DEFS_VH
`define HOST_PORT_DEFS_VH
`define ADDR_W 7
`define FIFO_ADDR_HI 6
`define FIFO_ADDR_LO 2
`define DATA_W 32
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define PINSEL_W 2
`define PINSEL_EEPROM 2'h0
`define PINSEL_GPO 2'h1
`define PINSEL_MON_DATA 2'h2
`define PINSEL_MON_CLK 2'h3
// Highest register word address: values up to and including it go to registers, the rest to FIFOs
`define FIFO_WINDOW_TOP 7'h0F
`define FIFO_RX_SEL 1'b0
// Edges after reset release before the synchronised strap is valid
`define STRAP_SETTLE 2'h2
`endif

/* rtl/sync2.v */
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module sync2 #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sync2

/* rtl/tx_fifo.v */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tx_fifo #(
  parameter W = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  output wire full,
  output wire empty
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire push;
  wire pop;
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      if (pop)
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // tx_fifo

/* rtl/host_port.v */
// Pin-level host port: access decode, byte order, width strap, wake, EEPROM pin mux, IRQ, TX FIFO
// Overview of operation
// (RQ1) Word address picks registers or data FIFOs
// (RQ2) FIFO select forces FIFO access, ignores upper address
// (RQ3) Byte-order pin: low little, high big endian
// (RQ4) Byte order sampled with address at strobe
// (RQ5) Access counts only with chip select low
// (RQ6) Host strobes read or write low
// (RQ7) Write with chip select wakes sleeping device
// (RQ8) Width strap latched at reset release
// (RQ9) Upper data pull-downs off in 32-bit mode
// (RQ10) Data pin: EEPROM, output or TX monitor
// (RQ11) Clock pin: EEPROM, output or RX monitor
// (RQ12) Interrupt: polarity, source mask, driver type selectable; polarity applies in push-pull only, open-drain always pulls low when active
// (RQ13) Host reads once before any write
// (RQ14) Drive data only during selected reads
`timescale 1ns/1ps
`include "host_port_defs.vh"
module host_port #(
  parameter DW = `DATA_W,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW,
  parameter NSRC = 8
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire RST_N,
  // Host bus pins
  input wire [`ADDR_W-1:0] ADDR,
  input wire [DW-1:0] DATA_IN,
  output reg [DW-1:0] DATA_OUT,
  output reg [DW-1:0] DATA_OE,
  output reg UPPER_PULLDOWN_EN,
  input wire READ_STROBE_N,
  input wire WRITE_STROBE_N,
  input wire CHIP_SELECT_N,
  input wire FIFO_SELECT,
  input wire BYTE_ORDER_SELECT,
  // Internal register path
  output reg REG_WRITE,
  output reg REG_READ,
  output reg [`ADDR_W-1:0] REG_ADDR,
  output reg [DW-1:0] REG_WDATA,
  input wire [DW-1:0] REG_RDATA,
  // Receive FIFO read side
  output reg RX_POP,
  input wire [DW-1:0] RX_DATA,
  // Transmit FIFO drain side
  output reg TX_VALID,
  input wire TX_READY,
  output reg [DW-1:0] TX_DATA,
  output reg TX_FULL,
  // Power and status
  input wire SLEEP_REQ,
  output reg ASLEEP,
  output reg WAKE,
  output reg WRITES_ENABLED,
  output reg BUS_32BIT,
  output reg BIG_ENDIAN,
  // EEPROM pins and mux control
  input wire [`PINSEL_W-1:0] DATA_PIN_SEL,
  input wire [`PINSEL_W-1:0] CLK_PIN_SEL,
  input wire GENERAL_OUTPUT_THREE,
  input wire GENERAL_OUTPUT_FOUR,
  input wire MON_TX_EN,
  input wire MON_TX_CLK,
  input wire MON_RX_DV,
  input wire MON_RX_CLK,
  input wire EE_SELECT,
  input wire EE_CLOCK,
  input wire EE_DATA_OUT,
  input wire EE_DATA_OE,
  output reg EE_DATA_IN,
  input wire EEPROM_SERIAL_IO_IN,
  output reg EEPROM_SERIAL_IO_OUT,
  output reg EEPROM_SERIAL_IO_OE,
  output reg EEPROM_SELECT,
  output reg EEPROM_SERIAL_CLOCK,
  // Interrupt
  input wire [NSRC-1:0] IRQ_SOURCES,
  input wire [NSRC-1:0] IRQ_ENABLE,
  input wire IRQ_POLARITY_HIGH,
  input wire IRQ_OPEN_DRAIN,
  output reg IRQ_OUT,
  output reg IRQ_OE
);
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_WRITE = 3'b100;
  wire [`ADDR_W-1:0] s_addr;
  wire [DW-1:0] s_data;
  wire s_rd;
  wire s_wr;
  wire s_cs;
  wire s_fsel;
  wire s_bo;
  wire s_strap;
  reg [2:0] state;
  reg strap_done;
  reg [1:0] strap_wait;
  reg is_fifo;
  reg [DW-1:0] rd_word;
  reg [DW-1:0] next_out;
  wire rd_active;
  wire wr_active;
  wire fifo_target;
  wire tx_in_ready;
  wire tx_out_valid;
  wire tx_full;
  wire [DW-1:0] tx_out_data;
  wire irq_active;
  // Pin inputs pass two flops before use; strobes enter inverted so cleared flops read as idle
  sync2 #(.W(`ADDR_W + DW + 6)) u_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .d({ADDR, DATA_IN, ~READ_STROBE_N, ~WRITE_STROBE_N, ~CHIP_SELECT_N, FIFO_SELECT, BYTE_ORDER_SELECT,
      EEPROM_SERIAL_IO_IN}),
    .q({s_addr, s_data, s_rd, s_wr, s_cs, s_fsel, s_bo, s_strap})
  );
  // Swap bytes of a word for big-endian hosts
  function [DW-1:0] order;
    input [DW-1:0] w;
    input big;
    integer i;
    begin
      order = w;
      if (big)
        for (i = 0; i < DW / 8; i = i + 1)
          order[i*8 +: 8] = w[(DW/8-1-i)*8 +: 8];
    end
  endfunction
  assign rd_active = s_cs && s_rd; // [RQ5] [RQ6]
  assign wr_active = s_cs && s_wr; // [RQ5] [RQ6]
  assign fifo_target = s_fsel || (s_addr > `FIFO_WINDOW_TOP); // [RQ1] [RQ2]
  tx_fifo #(.W(DW), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .in_valid(state == ST_WRITE && is_fifo && !wr_active && WRITES_ENABLED),
    .in_ready(tx_in_ready),
    .in_data(REG_WDATA),
    .out_valid(tx_out_valid),
    .out_ready(TX_READY && TX_VALID),
    .out_data(tx_out_data),
    .full(tx_full),
    .empty()
  );
  // Access sequencing: one strobe cycle gives one operation; register reads at its leading edge, writes and FIFO pops at its trailing edge
  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      state <= ST_IDLE;
      is_fifo <= 1'b0;
      REG_WRITE <= 1'b0;
      REG_READ <= 1'b0;
      RX_POP <= 1'b0;
      REG_ADDR <= {`ADDR_W{1'b0}};
      REG_WDATA <= {DW{1'b0}};
      BIG_ENDIAN <= 1'b0;
      WRITES_ENABLED <= 1'b0;
      ASLEEP <= 1'b0;
      WAKE <= 1'b0;
    end
    else
    begin
      REG_WRITE <= 1'b0;
      REG_READ <= 1'b0;
      RX_POP <= 1'b0;
      WAKE <= 1'b0;
      if (SLEEP_REQ && !ASLEEP)
      begin
        ASLEEP <= 1'b1;
        WRITES_ENABLED <= 1'b0; // [RQ13]
      end
      case (state)
        ST_IDLE:
        begin
          if (rd_active)
          begin
            state <= ST_READ;
            is_fifo <= fifo_target;
            REG_ADDR <= s_fsel ? {{(`ADDR_W-2){1'b0}}, s_addr[1:0]} : s_addr; // [RQ2]
            BIG_ENDIAN <= s_bo; // [RQ3] [RQ4]
            REG_READ <= !fifo_target; // [RQ1]
          end
          else if (wr_active)
          begin
            state <= ST_WRITE;
            is_fifo <= fifo_target;
            REG_ADDR <= s_fsel ? {{(`ADDR_W-2){1'b0}}, s_addr[1:0]} : s_addr; // [RQ2]
            BIG_ENDIAN <= s_bo; // [RQ4]
            if (ASLEEP)
            begin
              ASLEEP <= 1'b0; // [RQ7]
              WAKE <= 1'b1; // [RQ7]
            end
          end
        end
        ST_READ:
        begin
          if (!rd_active)
          begin
            state <= ST_IDLE;
            RX_POP <= is_fifo;
            WRITES_ENABLED <= !ASLEEP; // [RQ13]
          end
        end
        ST_WRITE:
        begin
          REG_WDATA <= order(s_data, BIG_ENDIAN); // [RQ3]
          if (!wr_active)
          begin
            state <= ST_IDLE;
            REG_WRITE <= !is_fifo && WRITES_ENABLED; // [RQ1] [RQ13]
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
  // Read data path and bus drivers
  always @*
  begin
    rd_word = is_fifo ? RX_DATA : REG_RDATA; // [RQ1]
    next_out = order(rd_word, BIG_ENDIAN); // [RQ3]
    if (!BUS_32BIT)
      next_out[DW-1:16] = {(DW-16){1'b0}};
  end
  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      DATA_OUT <= {DW{1'b0}};
      DATA_OE <= {DW{1'b0}};
      strap_done <= 1'b0;
      BUS_32BIT <= 1'b0;
      UPPER_PULLDOWN_EN <= 1'b1;
      TX_VALID <= 1'b0;
      TX_DATA <= {DW{1'b0}};
      TX_FULL <= 1'b0;
      strap_wait <= 2'h0;
    end
    else
    begin
      DATA_OUT <= next_out;
      if (state == ST_READ && rd_active)
        DATA_OE <= BUS_32BIT ? {DW{1'b1}} : {{(DW-16){1'b0}}, 16'hFFFF}; // [RQ14]
      else
        DATA_OE <= {DW{1'b0}}; // [RQ14]
      if (!strap_done)
      begin
        if (strap_wait == `STRAP_SETTLE)
        begin
          strap_done <= 1'b1;
          BUS_32BIT <= s_strap; // [RQ8]
          UPPER_PULLDOWN_EN <= !s_strap; // [RQ9]
        end
        else
          strap_wait <= strap_wait + 2'h1;
      end
      TX_VALID <= tx_out_valid && !(TX_VALID && TX_READY);
      TX_DATA <= tx_out_data;
      TX_FULL <= tx_full || !tx_in_ready;
    end
  end
  // EEPROM pin multiplexing and interrupt driver
  assign irq_active = |(IRQ_SOURCES & IRQ_ENABLE); // [RQ12]
  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      EEPROM_SERIAL_IO_OUT <= 1'b0;
      EEPROM_SERIAL_IO_OE <= 1'b0;
      EEPROM_SELECT <= 1'b0;
      EEPROM_SERIAL_CLOCK <= 1'b0;
      EE_DATA_IN <= 1'b0;
      IRQ_OUT <= 1'b0;
      IRQ_OE <= 1'b0;
    end
    else
    begin
      EE_DATA_IN <= s_strap;
      EEPROM_SELECT <= (DATA_PIN_SEL == `PINSEL_EEPROM) && (CLK_PIN_SEL == `PINSEL_EEPROM) && strap_done
        && EE_SELECT; // [RQ10] [RQ11]
      case (DATA_PIN_SEL)
        `PINSEL_EEPROM:
        begin
          EEPROM_SERIAL_IO_OUT <= EE_DATA_OUT;
          EEPROM_SERIAL_IO_OE <= EE_DATA_OE && strap_done;
        end
        `PINSEL_GPO:
        begin
          EEPROM_SERIAL_IO_OUT <= GENERAL_OUTPUT_THREE; // [RQ10]
          EEPROM_SERIAL_IO_OE <= strap_done;
        end
        `PINSEL_MON_DATA:
        begin
          EEPROM_SERIAL_IO_OUT <= MON_TX_EN; // [RQ10]
          EEPROM_SERIAL_IO_OE <= strap_done;
        end
        default:
        begin
          EEPROM_SERIAL_IO_OUT <= MON_TX_CLK; // [RQ10]
          EEPROM_SERIAL_IO_OE <= strap_done;
        end
      endcase
      case (CLK_PIN_SEL)
        `PINSEL_EEPROM:
          EEPROM_SERIAL_CLOCK <= EE_CLOCK;
        `PINSEL_GPO:
          EEPROM_SERIAL_CLOCK <= GENERAL_OUTPUT_FOUR; // [RQ11]
        `PINSEL_MON_DATA:
          EEPROM_SERIAL_CLOCK <= MON_RX_DV; // [RQ11]
        default:
          EEPROM_SERIAL_CLOCK <= MON_RX_CLK; // [RQ11]
      endcase
      if (IRQ_OPEN_DRAIN)
      begin
        IRQ_OUT <= 1'b0; // [RQ12]
        IRQ_OE <= irq_active;
      end
      else
      begin
        IRQ_OUT <= IRQ_POLARITY_HIGH ? irq_active : !irq_active; // [RQ12]
        IRQ_OE <= 1'b1;
      end
    end
  end
endmodule // host_port

/* tb/host_port_properties.sv */
// Concurrent checks on the host port pins
`timescale 1ns/1ps
`include "host_port_defs.vh"
module host_port_properties #(
  parameter DW = 32,
  parameter NSRC = 8
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire RST_N,
  // Host side
  input wire READ_STROBE_N,
  input wire CHIP_SELECT_N,
  input wire BYTE_ORDER_SELECT,
  input wire [DW-1:0] DATA_OE,
  input wire UPPER_PULLDOWN_EN,
  input wire BUS_32BIT,
  input wire BIG_ENDIAN,
  input wire REG_READ,
  input wire REG_WRITE,
  input wire [`ADDR_W-1:0] REG_ADDR,
  input wire WRITES_ENABLED,
  input wire WAKE,
  input wire ASLEEP,
  // EEPROM pins
  input wire [`PINSEL_W-1:0] DATA_PIN_SEL,
  input wire [`PINSEL_W-1:0] CLK_PIN_SEL,
  input wire GENERAL_OUTPUT_THREE,
  input wire MON_RX_CLK,
  input wire EEPROM_SELECT,
  input wire EEPROM_SERIAL_IO_OUT,
  input wire EEPROM_SERIAL_CLOCK,
  // Interrupt
  input wire [NSRC-1:0] IRQ_SOURCES,
  input wire [NSRC-1:0] IRQ_ENABLE,
  input wire IRQ_POLARITY_HIGH,
  input wire IRQ_OPEN_DRAIN,
  input wire IRQ_OUT,
  input wire IRQ_OE
);
  wire act = |(IRQ_SOURCES & IRQ_ENABLE);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  AST_PULLDOWN: assert property ($past(RST_N, 2) |-> UPPER_PULLDOWN_EN == !BUS_32BIT)
    else $error("pull-down state disagrees with bus width");
  AST_STRAP_HOLD: assert property ($past(RST_N, 4) |-> $stable(BUS_32BIT))
    else $error("bus width changed outside reset");
  AST_DRIVE_READ: assert property (|DATA_OE |->
    !($past(READ_STROBE_N, 3) && $past(READ_STROBE_N, 4) && $past(READ_STROBE_N, 5)))
    else $error("data driven without read strobe");
  AST_DRIVE_CS: assert property ($rose(|DATA_OE) |-> !$past(CHIP_SELECT_N, 2))
    else $error("data drive started without chip select");
  AST_REG_READ: assert property (REG_READ |->
    !$past(READ_STROBE_N, 2) && !$past(CHIP_SELECT_N, 2) && REG_ADDR <= `FIFO_WINDOW_TOP)
    else $error("register read without qualified strobe");
  AST_BYTE_ORDER: assert property (REG_READ |-> BIG_ENDIAN == $past(BYTE_ORDER_SELECT, 2))
    else $error("byte order not taken with the access");
  AST_READ_FIRST: assert property (REG_WRITE |-> WRITES_ENABLED)
    else $error("write accepted before a read");
  AST_WAKE: assert property (WAKE |-> $past(ASLEEP) ##[0:3] !ASLEEP)
    else $error("wake pulse without leaving sleep");
  AST_EE_SELECT: assert property ((DATA_PIN_SEL != `PINSEL_EEPROM || CLK_PIN_SEL != `PINSEL_EEPROM)
    |=> !EEPROM_SELECT)
    else $error("EEPROM select active in pin reuse mode");
  AST_GPO_DATA: assert property (DATA_PIN_SEL == `PINSEL_GPO |=>
    EEPROM_SERIAL_IO_OUT == $past(GENERAL_OUTPUT_THREE))
    else $error("data pin does not follow general output");
  AST_MON_CLK: assert property (CLK_PIN_SEL == `PINSEL_MON_CLK |=>
    EEPROM_SERIAL_CLOCK == $past(MON_RX_CLK))
    else $error("clock pin does not follow receive clock");
  AST_IRQ_OD: assert property (IRQ_OPEN_DRAIN |=> !IRQ_OUT && IRQ_OE == $past(act))
    else $error("open-drain interrupt wrong");
  AST_IRQ_PP: assert property (!IRQ_OPEN_DRAIN |=>
    IRQ_OE && IRQ_OUT == ($past(act) == $past(IRQ_POLARITY_HIGH)))
    else $error("push-pull interrupt wrong");
endmodule // host_port_properties
bind host_port host_port_properties #(.DW(DW), .NSRC(NSRC)) props (.CLK_SYS, .RST_N, .READ_STROBE_N,
  .CHIP_SELECT_N, .BYTE_ORDER_SELECT, .DATA_OE, .UPPER_PULLDOWN_EN, .BUS_32BIT, .BIG_ENDIAN, .REG_READ,
  .REG_WRITE, .REG_ADDR, .WRITES_ENABLED, .WAKE, .ASLEEP, .DATA_PIN_SEL, .CLK_PIN_SEL, .GENERAL_OUTPUT_THREE,
  .MON_RX_CLK, .EEPROM_SELECT, .EEPROM_SERIAL_IO_OUT, .EEPROM_SERIAL_CLOCK, .IRQ_SOURCES, .IRQ_ENABLE,
  .IRQ_POLARITY_HIGH, .IRQ_OPEN_DRAIN, .IRQ_OUT, .IRQ_OE);

/* tb/host_cpu_model.sv */
// Host CPU model driving the SRAM-like strobes
`timescale 1ns/1ps
module host_cpu_model (
  // Clock and data bus level
  input wire clk,
  input wire [31:0] bus,
  // Host pins
  output reg [6:0] addr,
  output reg [31:0] hd,
  output reg hoe,
  output reg rd_n,
  output reg wr_n,
  output reg cs_n,
  output reg fsel,
  output reg bsel
);
  initial
  begin
    {addr, hd, hoe, fsel, bsel} = 0;
    {rd_n, wr_n, cs_n} = 3'b111;
  end
  // Qualifiers settle a cycle ahead of the strobe and hold past its release
  task acc(input rw, input cs, input fs, input bs, input [6:0] a, input [31:0] wd, output [31:0] rv);
    begin
      @(posedge clk);
      addr <= a;
      fsel <= fs;
      bsel <= bs;
      hd <= wd;
      hoe <= !rw;
      cs_n <= !cs;
      @(posedge clk);
      rd_n <= !rw;
      wr_n <= rw;
      repeat (10) @(posedge clk);
      rv = bus;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      @(posedge clk);
      cs_n <= 1'b1;
      hoe <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // host_cpu_model

/* tb/host_port_bench.sv */
// Self-checking bench for the host port pins
`timescale 1ns/1ps
module host_port_bench;
  reg CLK_SYS, rst_n, strap, txr, slp, pol, od;
  reg [1:0] dsel, csel;
  reg [9:0] mon;
  reg [7:0] en;
  wire [31:0] DATA_OUT, DATA_OE, TX_DATA, bus, hd;
  wire [6:0] addr;
  wire hoe, rd_n, wr_n, cs_n, fsel, bsel, io_out, io_oe, ee_in;
  wire REG_WRITE, REG_READ, RX_POP, TX_VALID, TX_FULL, ASLEEP, WAKE, BUS_32BIT, UPPER_PULLDOWN_EN;
  wire EEPROM_SELECT, EEPROM_SERIAL_CLOCK, IRQ_OUT, IRQ_OE;
  wire [6:0] REG_ADDR;
  wire [31:0] REG_WDATA;
  reg [31:0] rv, wa, wd, tq;
  integer fails, compares, write_strobe_n, read_strobe_n, npop, nwake, ntx, i;
  assign bus = (DATA_OE & DATA_OUT) | (~DATA_OE & (hoe ? hd : ~hd & {UPPER_PULLDOWN_EN ? 16'h0000 : 16'hFFFF,
    16'hFFFF}));
  host_cpu_model h (.clk(CLK_SYS), .bus(bus), .addr(addr), .hd(hd), .hoe(hoe), .rd_n(rd_n), .wr_n(wr_n),
    .cs_n(cs_n), .fsel(fsel), .bsel(bsel));
  host_port DUT (.CLK_SYS(CLK_SYS), .RST_N(rst_n), .ADDR(addr), .DATA_IN(bus), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .UPPER_PULLDOWN_EN(UPPER_PULLDOWN_EN), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
    .CHIP_SELECT_N(cs_n), .FIFO_SELECT(fsel), .BYTE_ORDER_SELECT(bsel), .REG_WRITE(REG_WRITE),
    .REG_READ(REG_READ), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(32'h1122_3344),
    .RX_POP(RX_POP), .RX_DATA(32'h5566_7788), .TX_VALID(TX_VALID), .TX_READY(txr), .TX_DATA(TX_DATA),
    .TX_FULL(TX_FULL), .SLEEP_REQ(slp), .ASLEEP(ASLEEP), .WAKE(WAKE), .WRITES_ENABLED(), .BUS_32BIT(BUS_32BIT),
    .BIG_ENDIAN(), .DATA_PIN_SEL(dsel), .CLK_PIN_SEL(csel), .GENERAL_OUTPUT_THREE(mon[1]),
    .GENERAL_OUTPUT_FOUR(mon[5]), .MON_TX_EN(mon[2]), .MON_TX_CLK(mon[3]), .MON_RX_DV(mon[6]),
    .MON_RX_CLK(mon[7]), .EE_SELECT(mon[8]), .EE_CLOCK(mon[4]), .EE_DATA_OUT(mon[0]), .EE_DATA_OE(mon[9]),
    .EE_DATA_IN(ee_in), .EEPROM_SERIAL_IO_IN(io_oe ? io_out : strap), .EEPROM_SERIAL_IO_OUT(io_out),
    .EEPROM_SERIAL_IO_OE(io_oe), .EEPROM_SELECT(EEPROM_SELECT), .EEPROM_SERIAL_CLOCK(EEPROM_SERIAL_CLOCK),
    .IRQ_SOURCES(8'h01), .IRQ_ENABLE(en), .IRQ_POLARITY_HIGH(pol), .IRQ_OPEN_DRAIN(od), .IRQ_OUT(IRQ_OUT),
    .IRQ_OE(IRQ_OE));
  initial
  begin
    CLK_SYS = 0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS)
  begin
    if (REG_WRITE)
    begin
      write_strobe_n = write_strobe_n + 1;
      wa = REG_ADDR;
      wd = REG_WDATA;
    end
    read_strobe_n = read_strobe_n + REG_READ;
    npop = npop + RX_POP;
    nwake = nwake + WAKE;
    if (TX_VALID && txr && ntx == 0)
      tq = TX_DATA;
    ntx = ntx + (TX_VALID && txr);
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial
  begin
    #100_000;
    fails = fails + 1;
    results;
  end
  initial
  begin
    {fails, compares, write_strobe_n, read_strobe_n, npop, nwake, ntx} = 0;
    {rst_n, txr, slp, pol, od, dsel, csel, en} = 0;
    strap = 1;
    mon = 10'h35A;
    repeat (8) @(posedge CLK_SYS);
    rst_n <= 1;
    repeat (4) @(posedge CLK_SYS);
    chk(BUS_32BIT, 1);
    chk(UPPER_PULLDOWN_EN, 0);
    chk(ee_in, 1);
    h.acc(0, 1, 0, 0, 7'h05, 32'hA1B2_C3D4, rv);
    chk(write_strobe_n, 0);
    h.acc(1, 1, 0, 0, 7'h02, 0, rv);
    chk(rv, 32'h1122_3344);
    h.acc(1, 1, 0, 1, 7'h02, 0, rv);
    chk(rv, 32'h4433_2211);
    chk(read_strobe_n, 2);
    h.acc(1, 1, 0, 0, 7'h7F, 0, rv);
    chk(rv, 32'h5566_7788);
    h.acc(1, 1, 1, 0, 7'h02, 0, rv);
    chk({read_strobe_n[15:0], npop[15:0]}, 32'h0002_0002);
    h.acc(0, 0, 0, 0, 7'h05, 32'hA1B2_C3D4, rv);
    chk(write_strobe_n, 0);
    h.acc(0, 1, 0, 0, 7'h05, 32'hA1B2_C3D4, rv);
    chk({write_strobe_n[23:0], wa[7:0]}, 32'h0000_0105);
    chk(wd, 32'hA1B2_C3D4);
    h.acc(0, 1, 0, 1, 7'h06, 32'hA1B2_C3D4, rv);
    chk(wd, 32'hD4C3_B2A1);
    for (i = 0; i < 17; i = i + 1)
      h.acc(0, 1, 1, 0, 7'h01, 32'h0000_0100 + i, rv);
    chk(write_strobe_n, 2);
    chk(TX_FULL, 1);
    txr <= 1;
    repeat (40) @(posedge CLK_SYS);
    chk(ntx, 16);
    chk(tq, 32'h0000_0100);
    slp <= 1;
    repeat (3) @(posedge CLK_SYS);
    slp <= 0;
    repeat (3) @(posedge CLK_SYS);
    chk(ASLEEP, 1);
    h.acc(0, 1, 0, 0, 7'h05, 32'h0000_0001, rv);
    chk({nwake[15:0], 15'h0000, ASLEEP}, 32'h0001_0000);
    chk(write_strobe_n, 2);
    for (i = 0; i < 4; i = i + 1)
    begin
      dsel <= i[1:0];
      csel <= i[1:0];
      repeat (2) @(posedge CLK_SYS);
      chk(io_out, mon[i]);
      chk(io_oe, 1);
      chk(EEPROM_SERIAL_CLOCK, mon[4 + i]);
      chk(EEPROM_SELECT, i == 0);
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      en <= {7'h00, i[0]};
      pol <= i[1];
      od <= i[2];
      repeat (2) @(posedge CLK_SYS);
      chk({IRQ_OE, IRQ_OUT}, i[2] ? {i[0], 1'b0} : {1'b1, i[0] == i[1]});
    end
    // Second reset with the strap low: 16-bit bus, upper lanes left to the pull-downs
    strap <= 0;
    rst_n <= 0;
    repeat (8) @(posedge CLK_SYS);
    rst_n <= 1;
    repeat (4) @(posedge CLK_SYS);
    chk({BUS_32BIT, UPPER_PULLDOWN_EN, ee_in}, 3'b010);
    h.acc(1, 1, 0, 0, 7'h02, 0, rv);
    chk(rv, 32'h0000_3344);
    results;
  end
endmodule // host_port_bench
